// ==== logic/script_irq_pkg.sv ====
// shared constants and types of the script interrupt unit
// assumes one clock of 200 MHz and an APB register port
package script_irq_pkg;

   // ------------------------------------------------------------------
   // command codes and fields
   // ------------------------------------------------------------------
   localparam logic [7:0] OP_IRQ_ENABLE         = 8'h19;
   localparam logic [7:0] OP_IRQ_DISABLE        = 8'h1A;
   localparam logic [7:0] OP_VECTOR_BIND        = 8'h25;
   localparam logic [7:0] OP_HANDLER_RETURN     = 8'h26;
   localparam logic [7:0] OP_GLOBAL_PARAM_WRITE = 8'h09;
   localparam logic [7:0] IRQ_PARAM_BANK        = 8'h03;
   localparam logic [7:0] GLOBAL_IRQ_NUMBER     = 8'hFF;
   localparam logic [7:0] FIRST_TIMER_IRQ_NUMBER = 8'h00;

   // ------------------------------------------------------------------
   // sources
   // ------------------------------------------------------------------
   localparam int unsigned NSRC   = 11;
   localparam int unsigned NTIMER = 3;
   localparam int unsigned NPIN   = 8;
   localparam int unsigned NEDGE  = 5;
   localparam int unsigned IDX_W  = 4;
   localparam logic [IDX_W-1:0] IDX_NONE = 4'hF;
   localparam logic [7:0] SRC_NUMBER [NSRC] = '{
      8'h00, 8'h01, 8'h02, 8'h03, 8'h0F, 8'h15,
      8'h1B, 8'h1C, 8'h27, 8'h28, 8'h29};

   // ------------------------------------------------------------------
   // widths and timing
   // ------------------------------------------------------------------
   localparam int unsigned ACC_W         = 32;
   localparam int unsigned VEC_W_DEF     = 16;
   localparam int unsigned FLAG_W_DEF    = 4;
   localparam int unsigned TIMER_W       = 32;
   localparam int unsigned MS_NS         = 1000000;
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

   // ------------------------------------------------------------------
   // register map
   // ------------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam logic [ADDR_W-1:0] STATUS_OFF  = 8'h00;
   localparam logic [ADDR_W-1:0] MASK_OFF    = 8'h04;
   localparam logic [ADDR_W-1:0] PENDING_OFF = 8'h08;
   localparam logic [ADDR_W-1:0] ENABLE_OFF  = 8'h0C;
   localparam int unsigned ST_W          = 4;
   localparam int unsigned ST_ENTER_BIT  = 0;
   localparam int unsigned ST_RETURN_BIT = 1;
   localparam int unsigned ST_STRAY_BIT  = 2;
   localparam int unsigned ST_BADNUM_BIT = 3;
   localparam int unsigned VALID_LSB     = 16;
   localparam int unsigned GLOBAL_BIT    = 16;
   localparam int unsigned BUSY_BIT      = 17;
   localparam logic [ST_W-1:0]    STATUS_RST   = 4'h0;
   localparam logic [ST_W-1:0]    MASK_RST     = 4'h0;
   localparam logic [TIMER_W-1:0] INTERVAL_RST = 32'h0;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b01,
      ST_HANDLER = 2'b10
   } unit_state_type;

   // interrupt number to source slot, IDX_NONE if not a source
   function automatic logic [IDX_W-1:0] num_to_idx(input logic [7:0] n);
      logic [IDX_W-1:0] r;
      r = IDX_NONE;
      for (int i = 0; i < NSRC; i++) begin
         if (SRC_NUMBER[i] == n) begin
            r = IDX_W'(i);
         end
      end
      return r;
   endfunction

endpackage

// ==== logic/vector_store.sv ====
// handler address store, one word per interrupt source
// assumes single clock; read data registered, write forwarded to read
module vector_store #(
   parameter int unsigned DEPTH = 11,
   parameter int unsigned WIDTH = 16,
   parameter int unsigned IDX_W = 4
) (
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // write port
   input  wire logic             wr_en,
   input  wire logic [IDX_W-1:0] wr_idx,
   input  wire logic [WIDTH-1:0] wr_data,
   // read port
   input  wire logic [IDX_W-1:0] rd_idx,
   output logic      [WIDTH-1:0] rd_data
);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [WIDTH-1:0] rd_d;

   if (DEPTH > (1 << IDX_W)) begin : g_chk
      $error("vector_store: DEPTH exceeds index range");
   end

   always_comb begin
      rd_d = '0;
      if (wr_en && wr_idx == rd_idx) begin
         rd_d = wr_data;
      end else if (32'(rd_idx) < DEPTH) begin
         rd_d = mem[rd_idx];
      end
   end

   always_ff @(posedge pclk) begin
      if (wr_en && 32'(wr_idx) < DEPTH) begin
         mem[wr_idx] <= wr_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_data <= '0;
      end else begin
         rd_data <= rd_d;
      end
   end

endmodule

// ==== logic/script_interrupt_unit.sv ====
// interrupt unit beside a stored-program interpreter core
// assumes core on pclk, event lines asynchronous, APB register port
module script_interrupt_unit #(
   parameter int unsigned MS_CYC = script_irq_pkg::MS_CYCLES,
   parameter int unsigned VEC_W  = script_irq_pkg::VEC_W_DEF,
   parameter int unsigned FLAG_W = script_irq_pkg::FLAG_W_DEF
) (
   // clock and reset
   input  wire logic                               pclk,
   input  wire logic                               presetn,
   // apb slave
   input  wire logic                               psel,
   input  wire logic                               penable,
   input  wire logic                               pwrite,
   input  wire logic [script_irq_pkg::ADDR_W-1:0]  paddr,
   input  wire logic [31:0]                        pwdata,
   output logic      [31:0]                        prdata,
   output logic                                    pready,
   output logic                                    pslverr,
   // command strobe from the core
   input  wire logic                               cmd_valid,
   input  wire logic [7:0]                         cmd_opcode,
   input  wire logic [7:0]                         cmd_type,
   input  wire logic [7:0]                         cmd_bank,
   input  wire logic [31:0]                        cmd_value,
   // live context of the core
   input  wire logic [script_irq_pkg::ACC_W-1:0]   ctx_accu,
   input  wire logic [script_irq_pkg::ACC_W-1:0]   ctx_x,
   input  wire logic [FLAG_W-1:0]                  ctx_flags,
   input  wire logic [VEC_W-1:0]                   ctx_pc,
   // divert to handler
   output logic                                    divert_req,
   input  wire logic                               divert_ack,
   output logic      [VEC_W-1:0]                   divert_addr,
   output logic      [7:0]                         divert_number,
   // resume after handler
   output logic                                    resume_valid,
   output logic      [script_irq_pkg::ACC_W-1:0]   resume_accu,
   output logic      [script_irq_pkg::ACC_W-1:0]   resume_x,
   output logic      [FLAG_W-1:0]                  resume_flags,
   output logic      [VEC_W-1:0]                   resume_pc,
   // event lines
   input  wire logic                               pos_reached,
   input  wire logic                               load_stall,
   input  wire logic                               pos_deviation,
   input  wire logic                               stop_left,
   input  wire logic                               stop_right,
   input  wire logic [2:0]                         in_pins,
   // interrupt to the system
   output logic                                    irq_out
);

   localparam int unsigned NSRC  = script_irq_pkg::NSRC;
   localparam int unsigned IDX_W = script_irq_pkg::IDX_W;
   localparam int unsigned TW    = script_irq_pkg::TIMER_W;
   localparam int unsigned SW    = script_irq_pkg::ST_W;

   if (MS_CYC < 1 || VEC_W < 1 || VEC_W > 32 || FLAG_W < 1) begin : g_chk
      $error("script_interrupt_unit: unsupported parameter value");
   end

   // ------------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------------
   logic [IDX_W-1:0] cmd_idx;
   logic             cmd_known;
   logic             cmd_global;
   logic             do_enable;
   logic             do_disable;
   logic             do_bind;
   logic             do_return;
   logic             do_param;

   assign cmd_idx    = script_irq_pkg::num_to_idx(cmd_type);
   assign cmd_known  = cmd_idx != script_irq_pkg::IDX_NONE;
   assign cmd_global = cmd_type == script_irq_pkg::GLOBAL_IRQ_NUMBER;
   assign do_enable  = cmd_valid
      && cmd_opcode == script_irq_pkg::OP_IRQ_ENABLE;
   assign do_disable = cmd_valid
      && cmd_opcode == script_irq_pkg::OP_IRQ_DISABLE;
   assign do_bind    = cmd_valid
      && cmd_opcode == script_irq_pkg::OP_VECTOR_BIND;
   assign do_return  = cmd_valid
      && cmd_opcode == script_irq_pkg::OP_HANDLER_RETURN;
   assign do_param   = cmd_valid
      && cmd_opcode == script_irq_pkg::OP_GLOBAL_PARAM_WRITE
      && cmd_bank == script_irq_pkg::IRQ_PARAM_BANK;

   // ------------------------------------------------------------------
   // event synchronisers and edge detection
   // ------------------------------------------------------------------
   logic [script_irq_pkg::NPIN-1:0] pin_raw;
   logic [script_irq_pkg::NPIN-1:0] pin_edge;
   logic [script_irq_pkg::NTIMER-1:0] timer_fire;
   logic [NSRC-1:0] events;

   assign pin_raw = {in_pins, stop_right, stop_left, pos_deviation,
                     load_stall, pos_reached};

   for (genvar i = 0; i < script_irq_pkg::NPIN; i++) begin : g_pin
      logic s1_q;
      logic s2_q;
      logic s3_q;
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
         end else begin
            s1_q <= pin_raw[i];
            s2_q <= s1_q;
            s3_q <= s2_q;
         end
      end
      // status lines fire on rise, input pins on any change
      if (i < script_irq_pkg::NEDGE) begin : g_rise
         assign pin_edge[i] = s2_q & ~s3_q;
      end else begin : g_change
         assign pin_edge[i] = s2_q ^ s3_q;
      end
   end

   // slots 0-2 timers, 3.. pins in ascending interrupt number
   assign events = {pin_edge, timer_fire};

   // ------------------------------------------------------------------
   // interval timers
   // ------------------------------------------------------------------
   logic [31:0] pre_q;
   logic [31:0] pre_d;
   logic        ms_tick;

   always_comb begin
      ms_tick = pre_q == MS_CYC - 1;
      pre_d   = ms_tick ? 32'h0 : pre_q + 32'h1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_q <= 32'h0;
      end else begin
         pre_q <= pre_d;
      end
   end

   for (genvar t = 0; t < script_irq_pkg::NTIMER; t++) begin : g_tmr
      logic [TW-1:0] ival_q;
      logic [TW-1:0] ival_d;
      logic [TW-1:0] cnt_q;
      logic [TW-1:0] cnt_d;
      logic          fire;
      always_comb begin
         ival_d = ival_q;
         cnt_d  = cnt_q;
         fire   = 1'b0;
         if (do_param && cmd_type == 8'(t)) begin
            ival_d = cmd_value;
            cnt_d  = '0;
         end else if (ms_tick && ival_q != '0) begin
            if (cnt_q + TW'(1) >= ival_q) begin
               cnt_d = '0;
               fire  = 1'b1;
            end else begin
               cnt_d = cnt_q + TW'(1);
            end
         end
      end
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            ival_q <= script_irq_pkg::INTERVAL_RST;
            cnt_q  <= '0;
         end else begin
            ival_q <= ival_d;
            cnt_q  <= cnt_d;
         end
      end
      assign timer_fire[t] = fire;
   end

   // ------------------------------------------------------------------
   // source selection
   // ------------------------------------------------------------------
   logic [NSRC-1:0]  pend_q;
   logic [NSRC-1:0]  en_q;
   logic [NSRC-1:0]  valid_q;
   logic             global_q;
   script_irq_pkg::unit_state_type state_q;
   logic [IDX_W-1:0] sel_q;
   logic [NSRC-1:0]  ready_vec;
   logic             found;
   logic [IDX_W-1:0] found_idx;
   logic             accept;

   assign ready_vec = pend_q & en_q & valid_q;

   always_comb begin
      found     = 1'b0;
      found_idx = '0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (ready_vec[i]) begin
            found     = 1'b1;
            found_idx = IDX_W'(i);
         end
      end
   end

   // request only once the vector read matches the chosen slot
   assign divert_req = state_q == script_irq_pkg::ST_IDLE
      && global_q && found && found_idx == sel_q;
   assign accept = divert_req && divert_ack;

   vector_store #(
      .DEPTH (NSRC),
      .WIDTH (VEC_W),
      .IDX_W (IDX_W)
   ) u_vectors (
      .pclk    (pclk),
      .presetn (presetn),
      .wr_en   (do_bind && cmd_known),
      .wr_idx  (cmd_idx),
      .wr_data (cmd_value[VEC_W-1:0]),
      .rd_idx  (found_idx),
      .rd_data (divert_addr)
   );

   // ------------------------------------------------------------------
   // core state: enables, pending, context
   // ------------------------------------------------------------------
   script_irq_pkg::unit_state_type state_d;
   logic [NSRC-1:0]   pend_d;
   logic [NSRC-1:0]   en_d;
   logic [NSRC-1:0]   valid_d;
   logic              global_d;
   logic [7:0]        num_d;
   logic [script_irq_pkg::ACC_W-1:0] accu_d;
   logic [script_irq_pkg::ACC_W-1:0] x_d;
   logic [FLAG_W-1:0] flags_d;
   logic [VEC_W-1:0]  pc_d;
   logic [NSRC-1:0]   take_mask;

   assign resume_valid = do_return
      && state_q == script_irq_pkg::ST_HANDLER;

   always_comb begin
      state_d   = state_q;
      en_d      = en_q;
      valid_d   = valid_q;
      global_d  = global_q;
      num_d     = script_irq_pkg::SRC_NUMBER[found_idx];
      accu_d    = resume_accu;
      x_d       = resume_x;
      flags_d   = resume_flags;
      pc_d      = resume_pc;
      take_mask = '0;
      if (accept) begin
         take_mask[sel_q] = 1'b1;
         state_d = script_irq_pkg::ST_HANDLER;
         accu_d  = ctx_accu;
         x_d     = ctx_x;
         flags_d = ctx_flags;
         pc_d    = ctx_pc;
      end
      if (resume_valid) begin
         state_d = script_irq_pkg::ST_IDLE;
      end
      // a new event wins over the clear of its pending bit
      pend_d = (pend_q & ~take_mask) | events;
      if (do_enable && cmd_global) begin
         global_d = 1'b1;
      end else if (do_enable && cmd_known) begin
         en_d[cmd_idx] = 1'b1;
      end
      if (do_disable && cmd_global) begin
         global_d = 1'b0;
      end else if (do_disable && cmd_known) begin
         en_d[cmd_idx] = 1'b0;
      end
      if (do_bind && cmd_known) begin
         valid_d[cmd_idx] = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q       <= script_irq_pkg::ST_IDLE;
         pend_q        <= '0;
         en_q          <= '0;
         valid_q       <= '0;
         global_q      <= 1'b0;
         sel_q         <= '0;
         divert_number <= 8'h00;
         resume_accu   <= '0;
         resume_x      <= '0;
         resume_flags  <= '0;
         resume_pc     <= '0;
      end else begin
         state_q       <= state_d;
         pend_q        <= pend_d;
         en_q          <= en_d;
         valid_q       <= valid_d;
         global_q      <= global_d;
         sel_q         <= found_idx;
         divert_number <= num_d;
         resume_accu   <= accu_d;
         resume_x      <= x_d;
         resume_flags  <= flags_d;
         resume_pc     <= pc_d;
      end
   end

   // ------------------------------------------------------------------
   // apb registers and interrupt output
   // ------------------------------------------------------------------
   logic [SW-1:0] status_q;
   logic [SW-1:0] status_d;
   logic [SW-1:0] mask_q;
   logic [SW-1:0] mask_d;
   logic [SW-1:0] st_set;
   logic [31:0]   prdata_d;
   logic          wr_acc;
   logic          mapped;

   assign pready  = 1'b1;
   assign mapped  = paddr == script_irq_pkg::STATUS_OFF
      || paddr == script_irq_pkg::MASK_OFF
      || paddr == script_irq_pkg::PENDING_OFF
      || paddr == script_irq_pkg::ENABLE_OFF;
   assign pslverr = psel && penable && !mapped;
   assign wr_acc  = psel && penable && pwrite && mapped;
   assign irq_out = |(status_q & mask_q);

   always_comb begin
      st_set = '0;
      st_set[script_irq_pkg::ST_ENTER_BIT]  = accept;
      st_set[script_irq_pkg::ST_RETURN_BIT] = resume_valid;
      st_set[script_irq_pkg::ST_STRAY_BIT]  = do_return
         && state_q != script_irq_pkg::ST_HANDLER;
      st_set[script_irq_pkg::ST_BADNUM_BIT] = (do_enable || do_disable)
         && !cmd_known && !cmd_global
         || (do_bind || do_param) && !cmd_known;
      status_d = status_q;
      mask_d   = mask_q;
      if (wr_acc && paddr == script_irq_pkg::STATUS_OFF) begin
         status_d = status_q & ~pwdata[SW-1:0];
      end else if (wr_acc && paddr == script_irq_pkg::MASK_OFF) begin
         mask_d = pwdata[SW-1:0];
      end
      status_d = status_d | st_set;
      prdata_d = prdata;
      if (psel && !penable) begin
         prdata_d = 32'h0;
         if (paddr == script_irq_pkg::STATUS_OFF) begin
            prdata_d[SW-1:0] = status_q;
         end else if (paddr == script_irq_pkg::MASK_OFF) begin
            prdata_d[SW-1:0] = mask_q;
         end else if (paddr == script_irq_pkg::PENDING_OFF) begin
            prdata_d[NSRC-1:0] = pend_q;
            prdata_d[script_irq_pkg::VALID_LSB +: NSRC] = valid_q;
         end else if (paddr == script_irq_pkg::ENABLE_OFF) begin
            prdata_d[NSRC-1:0] = en_q;
            prdata_d[script_irq_pkg::GLOBAL_BIT] = global_q;
            prdata_d[script_irq_pkg::BUSY_BIT] =
               state_q == script_irq_pkg::ST_HANDLER;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_q <= script_irq_pkg::STATUS_RST;
         mask_q   <= script_irq_pkg::MASK_RST;
         prdata   <= 32'h0;
      end else begin
         status_q <= status_d;
         mask_q   <= mask_d;
         prdata   <= prdata_d;
      end
   end

endmodule

// ==== testbench/script_irq_monitor.sv ====
// port checker of the script interrupt unit
// assumes a bind onto script_interrupt_unit
module script_irq_monitor (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [7:0]  paddr,
   input wire logic        pready,
   input wire logic        pslverr,
   // commands and context
   input wire logic        cmd_valid,
   input wire logic [7:0]  cmd_opcode,
   input wire logic [7:0]  cmd_type,
   input wire logic        divert_req,
   input wire logic        divert_ack,
   input wire logic [7:0]  divert_number,
   input wire logic [31:0] ctx_accu,
   input wire logic [31:0] ctx_x,
   input wire logic [3:0]  ctx_flags,
   input wire logic [15:0] ctx_pc,
   input wire logic        resume_valid,
   input wire logic [31:0] resume_accu,
   input wire logic [31:0] resume_x,
   input wire logic [3:0]  resume_flags,
   input wire logic [15:0] resume_pc
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic acc = divert_req && divert_ack;
   property p_ready; psel && penable |-> pready; endproperty
   a_ready: assert property (p_ready)
      else $error("apb ready low");
   property p_err; pslverr |-> psel && penable; endproperty
   a_err: assert property (p_err)
      else $error("error outside access");
   property p_unmap;
      psel && penable && !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C})
         |-> pslverr;
   endproperty
   a_unmap: assert property (p_unmap)
      else $error("unmapped address accepted");
   property p_num;
      divert_req |-> divert_number inside {8'd0, 8'd1, 8'd2, 8'd3,
         8'd15, 8'd21, 8'd27, 8'd28, 8'd39, 8'd40, 8'd41};
   endproperty
   a_num: assert property (p_num)
      else $error("bad interrupt number");
   property p_save;
      acc |=> resume_accu == $past(ctx_accu) && resume_x == $past(ctx_x)
         && resume_flags == $past(ctx_flags) && resume_pc == $past(ctx_pc);
   endproperty
   a_save: assert property (p_save)
      else $error("context not saved");
   property p_nest; acc |=> !divert_req [*2]; endproperty
   a_nest: assert property (p_nest)
      else $error("request while in handler");
   property p_res;
      resume_valid |-> cmd_valid
         && cmd_opcode == script_irq_pkg::OP_HANDLER_RETURN;
   endproperty
   a_res: assert property (p_res)
      else $error("resume without return");
   property p_keep;
      !acc |=> $stable(resume_accu) && $stable(resume_x)
         && $stable(resume_flags) && $stable(resume_pc);
   endproperty
   a_keep: assert property (p_keep)
      else $error("saved context changed");
   property p_goff;
      cmd_valid && cmd_opcode == script_irq_pkg::OP_IRQ_DISABLE
         && cmd_type == script_irq_pkg::GLOBAL_IRQ_NUMBER |=> !divert_req;
   endproperty
   a_goff: assert property (p_goff)
      else $error("request after global off");
   c_enter: cover property (acc);
   c_resume: cover property (resume_valid);
   c_err: cover property (pslverr);
endmodule

// ==== testbench/script_core_model.sv ====
// interpreter core model on the divert side
// assumes pclk domain; acks after a random wait
module script_core_model (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // divert handshake
   input  wire logic        divert_req,
   output logic             divert_ack,
   // live context
   output logic [31:0]      ctx_accu,
   output logic [31:0]      ctx_x,
   output logic [3:0]       ctx_flags,
   output logic [15:0]      ctx_pc
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         divert_ack <= 1'b0;
         {ctx_accu, ctx_x, ctx_flags, ctx_pc} <= '0;
      end else begin
         // one ack per request, prompt or slow
         divert_ack <= !divert_ack && divert_req
            && $urandom_range(2, 0) == 0;
         // context moves every cycle so a stale save shows
         {ctx_accu, ctx_x} <= {$urandom, $urandom};
         {ctx_flags, ctx_pc} <= 20'($urandom);
      end
   end
endmodule

// ==== testbench/script_interrupt_unit_tb_top.sv ====
// self-checking bench of the script interrupt unit
// assumes monitor and core model compiled first
`define CHK(a, e) begin \
   n_tests++; \
   if ((a) !== (e)) begin \
      bad_count++; \
      $display("mismatch at %0t: %h vs %h", $time, a, e); \
   end \
end
module script_interrupt_unit_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        cmd_valid, divert_req, divert_ack, resume_valid, irq_out;
   logic        pos_reached, load_stall, pos_deviation, stop_left;
   logic        stop_right;
   logic [2:0]  in_pins;
   logic [3:0]  ctx_flags, resume_flags;
   logic [4:0]  ev;
   logic [7:0]  paddr, cmd_opcode, cmd_type, cmd_bank, divert_number, num;
   logic [15:0] ctx_pc, resume_pc, divert_addr, vt[11];
   logic [31:0] pwdata, prdata, cmd_value, ctx_accu, ctx_x;
   logic [31:0] resume_accu, resume_x, rq[$], dq[$];
   int          bad_count, n_tests;
   assign {stop_right, stop_left, pos_deviation, load_stall, pos_reached} = ev;
   script_interrupt_unit #(.MS_CYC(10)) script_interrupt_unit_inst (.*);
   script_core_model script_core_model_inst (.*);
   always #2.5 pclk = !pclk;
   // ---
   // result watcher
   // ---
   always @(posedge pclk) begin
      logic [31:0] e;
      if (presetn && psel && penable && pready && !pwrite) begin
         e = rq.size() ? rq.pop_front() : ~prdata;
         `CHK(prdata, e)
      end
      if (presetn && divert_req && divert_ack) begin
         e = dq.size() ? dq.pop_front() : '1;
         `CHK({8'h0, divert_number, divert_addr}, e)
      end
   end
   task automatic results();
      // expected results never seen count as mismatches
      bad_count += dq.size() + rq.size();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, logic [31:0] d);
      psel <= 1'b1;
      {pwrite, paddr, pwdata} <= {w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      for (int n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready) break;
      end
      if (!pready) begin
         bad_count++;
         results();
      end
      {psel, penable} <= 2'b00;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rq.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic cmd(input logic [7:0] op, t, logic [31:0] v = 0,
                      logic [7:0] b = 8'h00);
      cmd_valid <= 1'b1;
      {cmd_opcode, cmd_type, cmd_value, cmd_bank} <= {op, t, v, b};
      @(posedge pclk);
      cmd_valid <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wacc();
      for (int n = 0; n < 300; n++) begin
         @(negedge pclk);
         if (divert_req && divert_ack) break;
      end
      if (!(divert_req && divert_ack)) begin
         bad_count++;
         results();
      end
      @(posedge pclk);
      repeat (3) @(posedge pclk);
   endtask
   task automatic irq(input logic e);
      @(negedge pclk);
      `CHK(irq_out, e)
      @(posedge pclk);
   endtask
   initial begin
      void'($urandom(76237));
      {pclk, presetn, psel, penable, pwrite, cmd_valid, ev, in_pins} = '0;
      {paddr, pwdata, cmd_opcode, cmd_type, cmd_bank, cmd_value} = '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int a = 0; a < 20; a += 4) rd(8'(a), 32'h0);
      // event before its vector stays pending
      cmd(script_irq_pkg::OP_IRQ_ENABLE, 8'd3);
      cmd(script_irq_pkg::OP_IRQ_ENABLE, 8'hFF);
      ev <= 5'h01;
      repeat (20) @(posedge pclk);
      ev <= 5'h00;
      dq.push_back({8'd3, 16'h0123});
      cmd(script_irq_pkg::OP_VECTOR_BIND, 8'd3, 32'h0123);
      wacc();
      cmd(script_irq_pkg::OP_HANDLER_RETURN, 8'h00);
      for (int i = 0; i < 11; i++) begin
         num = script_irq_pkg::SRC_NUMBER[i];
         vt[i] = 16'($urandom);
         dq.push_back({num, vt[i]});
         cmd(script_irq_pkg::OP_VECTOR_BIND, num, 32'(vt[i]));
         if (i < 3)
            cmd(script_irq_pkg::OP_GLOBAL_PARAM_WRITE, num, 1, 3);
         cmd(script_irq_pkg::OP_IRQ_ENABLE, num);
         if (i inside {[3:7]}) ev[i-3] <= 1'b1;
         if (i > 7) in_pins[i-8] <= !in_pins[i-8];
         wacc();
         ev <= 5'h00;
         cmd(script_irq_pkg::OP_IRQ_DISABLE, num);
         if (i < 3) cmd(script_irq_pkg::OP_GLOBAL_PARAM_WRITE, num, 0, 3);
         cmd(script_irq_pkg::OP_HANDLER_RETURN, 8'h00);
      end
      // two events held back, then served in number order
      cmd(script_irq_pkg::OP_IRQ_DISABLE, 8'hFF);
      in_pins <= in_pins ^ 3'h3;
      repeat (20) @(posedge pclk);
      dq.push_back({8'd39, vt[8]});
      dq.push_back({8'd40, vt[9]});
      cmd(script_irq_pkg::OP_IRQ_ENABLE, 8'd40);
      cmd(script_irq_pkg::OP_IRQ_ENABLE, 8'd39);
      cmd(script_irq_pkg::OP_IRQ_ENABLE, 8'hFF);
      wacc();
      cmd(script_irq_pkg::OP_HANDLER_RETURN, 8'h00);
      wacc();
      cmd(script_irq_pkg::OP_HANDLER_RETURN, 8'h00);
      // stray return, unknown number, status and mask
      cmd(script_irq_pkg::OP_HANDLER_RETURN, 8'h00);
      cmd(script_irq_pkg::OP_IRQ_ENABLE, 8'd5);
      rd(script_irq_pkg::STATUS_OFF, 32'hF);
      rd(script_irq_pkg::ENABLE_OFF, 32'h0001_0300);
      irq(1'b0);
      apb(1'b1, script_irq_pkg::MASK_OFF, 32'h4);
      irq(1'b1);
      apb(1'b1, script_irq_pkg::STATUS_OFF, 32'hF);
      irq(1'b0);
      rd(script_irq_pkg::MASK_OFF, 32'h4);
      rd(script_irq_pkg::STATUS_OFF, 32'h0);
      results();
   end
endmodule
bind script_interrupt_unit script_irq_monitor script_irq_monitor_inst (.*);
